/* File: hw/frame_list_pkg.sv */
/*
  Constants shared by the frame list address and frame timing logic:
  register offsets, field positions, reset values and frame length figures.
  Assumes the I/O offsets are taken relative to the controller's I/O base.
*/
package frame_list_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_LIST_BASE = 8'h08;
  localparam logic [7:0] OFS_TIMING_ADJ = 8'h0c;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int BASE_LSB = 12;
  localparam int ADJ_W = 7;
  localparam int FRAME_INDEX_COUNTER_W = 11;
  localparam int INDEX_W = 10;
  localparam logic [31:0] LIST_BASE_RESET = 32'h0000_0000;
  localparam logic [6:0] ADJ_RESET = 7'h40;

  // ----------------------------------------------------------------------
  // Frame length in frame-clock periods
  // ----------------------------------------------------------------------
  localparam int LEN_W = 14;
  localparam logic [13:0] FRAME_LEN_BASE = 14'h2ea0;
  localparam logic [13:0] FRAME_LEN_RESET = 14'h2ee0;

endpackage

/* File: hw/frame_timer.sv */
/*
  Frame length timer: counts synchronised frame-clock ticks and marks the
  end of each frame. Assumes tick is a one-cycle pulse on mclk, one per
  frame-clock period, and that the adjust value is stable on mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module frame_timer
  import frame_list_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hcReset,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic [6:0] adjust,
  // Frame boundary
  output logic frameEnd
);

  logic [13:0] cntReg;
  logic [13:0] lenReg;
  logic [13:0] newLen;
  logic lastTick;

  // ----------------------------------------------------------------------
  // Length decode
  // ----------------------------------------------------------------------
  // The adjust value is sampled only at a boundary or while stopped or in
  // controller reset, so a write never stretches or cuts the frame under way.
  assign newLen = FRAME_LEN_BASE + {7'h00, adjust};
  assign lastTick = tick && (cntReg == lenReg - 14'h0001);

  // Count ticks; reload length and restart at each frame boundary.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cntReg <= 14'h0000;
      lenReg <= FRAME_LEN_RESET;
      frameEnd <= 1'b0;
    end
    else if (hcReset || !run)
    begin
      cntReg <= 14'h0000;
      lenReg <= newLen;
      frameEnd <= 1'b0;
    end
    else
    begin
      frameEnd <= lastTick;
      if (lastTick)
      begin
        cntReg <= 14'h0000;
        lenReg <= newLen;
      end
      else if (tick)
      begin
        cntReg <= cntReg + 14'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_frameLength;
    @(posedge mclk) disable iff (!rst_n || hcReset || !run)
    lastTick |=> lenReg == FRAME_LEN_BASE + {7'h00, $past(adjust)} && cntReg == 14'h0000;
  endproperty
  a_frameLength: assert property (p_frameLength)
    else $error("frame ended at wrong tick count");

  property p_lenHeld;
    @(posedge mclk) disable iff (!rst_n || hcReset)
    (run && !lastTick && $past(run)) |=> $stable(lenReg);
  endproperty
  a_lenHeld: assert property (p_lenHeld)
    else $error("frame length changed inside a frame");

  property p_endPulse;
    @(posedge mclk) disable iff (!rst_n || hcReset || !run)
    lastTick |=> frameEnd ##1 !frameEnd;
  endproperty
  a_endPulse: assert property (p_endPulse)
    else $error("frame end not a single pulse after boundary");

  c_frameEnd: cover property (@(posedge mclk) disable iff (!rst_n) frameEnd);

endmodule

`default_nettype wire

/* File: hw/usb_frame_list_and_sof_timing.sv */
/*
  Frame list entry address and start-of-frame timing for a USB host
  controller. Holds the frame list base and frame timing adjust registers on
  a byte-enabled I/O port, counts frames and forms each entry address.
  Assumes I/O strobes are one-cycle pulses on mclk, the 12 MHz frame clock
  arrives on a pin unrelated to mclk, and hcReset/run come from mclk logic.
*/
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Base register keeps only bits 31:12; bits 11:0 always read zero.
// - Entry address joins stored base bits 31:12 with the frame counter.
// - Entry address bits 1:0 are always zero; list holds 1024 entries.
// - Adjust register is 8 bits; only bits 6:0 matter, bit 7 reserved.
// - A new adjust value takes effect from the next frame only.
// - Frame lasts 11936 plus adjust value frame-clock periods.
// - Adjust value defaults to 64, giving 12000 clocks per frame.
// - Default adjust with 12 MHz frame clock gives a 1 ms frame.
// - Adjust register returns to default on controller or global reset.
// - Adjust may be rewritten any time, also while running.
// - Frame counter bits 9:0 drive entry address bits 11:2.
// - Eleven-bit frame counter increments once at every frame end.
module usb_frame_list_and_sof_timing
  import frame_list_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hcReset,
  // Schedule control
  input wire logic run,
  // Frame clock pin
  input wire logic frameClk,
  // I/O register port
  input wire logic [7:0] ioAddr,
  input wire logic [3:0] ioBe,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [31:0] ioWrData,
  output logic [31:0] ioRdData,
  output logic ioRdValid,
  // Frame outputs
  output logic [10:0] frame_index_counter,
  output logic [31:0] entryAddr,
  output logic sofStart
);

  logic [31:0] frame_list_base_address_reg;
  logic [6:0] frame_timing_adjust_reg;
  logic [31:0] baseNext;
  logic [6:0] adjNext;
  logic [31:0] rdNext;
  logic [31:0] entryAddrNext;
  logic selBase;
  logic selAdj;
  logic clkSync1;
  logic clkSync2;
  logic clkSync3;
  logic tick;
  logic frameEnd;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // A byte is written only if its lane is enabled, so byte and word writes
  // both work; lanes that fall below bit 12 are dropped on purpose.
  function automatic logic [7:0] laneMerge(input logic [7:0] oldByte,
                                           input logic [7:0] newByte,
                                           input logic en);
    laneMerge = en ? newByte : oldByte;
  endfunction

  assign selBase = (ioAddr == OFS_LIST_BASE);
  assign selAdj = (ioAddr == OFS_TIMING_ADJ);
  assign baseNext = {laneMerge(frame_list_base_address_reg[31:24], ioWrData[31:24], ioBe[3]),
                     laneMerge(frame_list_base_address_reg[23:16], ioWrData[23:16], ioBe[2]),
                     laneMerge(frame_list_base_address_reg[15:8],
                               ioWrData[15:8], ioBe[1]) & 8'hf0,
                     8'h00} & 32'hffff_f000;
  assign adjNext = ioBe[0] ? ioWrData[6:0] : frame_timing_adjust_reg;
  assign rdNext = selBase ? frame_list_base_address_reg :
                  selAdj ? {25'h0000000, frame_timing_adjust_reg} : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Base register: low twelve bits never store anything.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      frame_list_base_address_reg <= LIST_BASE_RESET;
    else if (ioWr && selBase)
      frame_list_base_address_reg <= baseNext;
  end

  // Adjust register: both resets restore the default; writes are taken
  // even while frames run, since the timer only samples at boundaries.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      frame_timing_adjust_reg <= ADJ_RESET;
    else if (hcReset)
      frame_timing_adjust_reg <= ADJ_RESET;
    else if (ioWr && selAdj)
      frame_timing_adjust_reg <= adjNext;
  end

  // Read answer one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ioRdData <= 32'h0000_0000;
      ioRdValid <= 1'b0;
    end
    else
    begin
      ioRdValid <= ioRd;
      if (ioRd)
        ioRdData <= rdNext;
    end
  end

  // ----------------------------------------------------------------------
  // Frame clock synchroniser
  // ----------------------------------------------------------------------
  // At 25 MHz the 12 MHz clock is sampled barely above twice per period;
  // the edge detector looks only at the second and third stages.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkSync1 <= 1'b0;
      clkSync2 <= 1'b0;
      clkSync3 <= 1'b0;
    end
    else
    begin
      clkSync1 <= frameClk;
      clkSync2 <= clkSync1;
      clkSync3 <= clkSync2;
    end
  end

  assign tick = clkSync2 && !clkSync3;

  // Frame length timer; the adjust value feeds it directly and is latched
  // there at each boundary.
  frame_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .hcReset(hcReset),
    .run(run),
    .tick(tick),
    .adjust(frame_timing_adjust_reg),
    .frameEnd(frameEnd)
  );

  // ----------------------------------------------------------------------
  // Frame counter and entry address
  // ----------------------------------------------------------------------
  assign entryAddrNext = {frame_list_base_address_reg[31:BASE_LSB],
                          frame_index_counter[INDEX_W-1:0], 2'b00};

  // Frame number and start-of-frame marker follow the timer's boundary.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_index_counter <= 11'h000;
      sofStart <= 1'b0;
    end
    else if (hcReset)
    begin
      frame_index_counter <= 11'h000;
      sofStart <= 1'b0;
    end
    else
    begin
      sofStart <= frameEnd;
      if (frameEnd)
        frame_index_counter <= frame_index_counter + 11'h001;
    end
  end

  // Entry address registered so it is a clean flop output.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      entryAddr <= 32'h0000_0000;
    else
      entryAddr <= entryAddrNext;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [19:0] baseHi;
  logic [9:0] idxLo;
  assign baseHi = frame_list_base_address_reg[31:12];
  assign idxLo = frame_index_counter[9:0];

  property p_baseLow;
    @(posedge mclk) disable iff (!rst_n)
    (ioWr && selBase && (&ioBe[3:1])) |=>
      frame_list_base_address_reg == {$past(ioWrData[31:12]), 12'h000};
  endproperty
  a_baseLow: assert property (p_baseLow)
    else $error("base register low bits or upper bits wrong after write");

  property p_addrForm;
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> entryAddr[31:12] == $past(baseHi) && entryAddr[11:2] == $past(idxLo);
  endproperty
  a_addrForm: assert property (p_addrForm)
    else $error("entry address does not join base and frame index");

  property p_addrAlign;
    @(posedge mclk) disable iff (!rst_n)
    entryAddr[1:0] == 2'b00;
  endproperty
  a_addrAlign: assert property (p_addrAlign)
    else $error("entry address not dword aligned");

  property p_adjDefault;
    @(posedge mclk) disable iff (!rst_n)
    hcReset |=> frame_timing_adjust_reg == ADJ_RESET;
  endproperty
  a_adjDefault: assert property (p_adjDefault)
    else $error("adjust not at default after controller reset");

  property p_adjWrite;
    @(posedge mclk) disable iff (!rst_n)
    (ioWr && selAdj && ioBe[0] && !hcReset) |=>
      frame_timing_adjust_reg == $past(ioWrData[6:0]);
  endproperty
  a_adjWrite: assert property (p_adjWrite)
    else $error("adjust write not taken");

  property p_frameInc;
    @(posedge mclk) disable iff (!rst_n || hcReset)
    frameEnd |=> frame_index_counter == $past(frame_index_counter) + 11'h001 ##1 sofStart == 1'b0;
  endproperty
  a_frameInc: assert property (p_frameInc)
    else $error("frame counter did not step once at frame end");

  c_sof: cover property (@(posedge mclk) disable iff (!rst_n) sofStart);
  c_adjRunWrite: cover property (@(posedge mclk) disable iff (!rst_n)
    run && ioWr && selAdj);
  c_wrap: cover property (@(posedge mclk) disable iff (!rst_n)
    sofStart && frame_index_counter == 11'h000);

endmodule

`default_nettype wire

/* File: test/frame_clock_source.sv */
/*
  Stand-in for the oscillator that drives the frame counter clock pin.
  Assumes the bench clock is 40 ns with rising edges at 20 ns plus whole periods.
*/
`timescale 1ns/10ps
`default_nettype none

module frame_clock_source
#(
  parameter int HALF_NS = 40,
  parameter int START_NS = 7
)
(
  // Frame clock pin
  output logic frameClk
);
  // ----------------------------------------------------------------------
  // Free-running clock
  // ----------------------------------------------------------------------
  // The period is two bench clocks, faster than the real rate, so that each
  // edge is seen exactly once and frame lengths become exact cycle counts.
  // The offset keeps every edge away from the bench clock's rising edge.
  initial
  begin
    frameClk = 1'b0;
    #START_NS;
    forever #HALF_NS frameClk = ~frameClk;
  end
endmodule

`default_nettype wire

/* File: test/tb_top.sv */
/*
  Self-checking bench for the frame list address and frame timing block.
  Assumes the design package is compiled first and the clock source model beside it.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import frame_list_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] exp;} row_t;
  logic mclk = 1'b0;
  logic rst_n, hcReset, run, ioWr, ioRd, ioRdValid, sofStart;
  logic [7:0] ioAddr;
  logic [3:0] ioBe;
  logic [31:0] ioWrData, ioRdData, entryAddr;
  logic [10:0] frame_index_counter;
  wire logic frameClk;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int lens[$];
  row_t rows [7];

  // ----------------------------------------------------------------------
  // Clock, far side and design
  // ----------------------------------------------------------------------
  always #20 mclk = ~mclk;
  frame_clock_source u_src (.frameClk(frameClk));
  usb_frame_list_and_sof_timing u_dut (.mclk(mclk), .rst_n(rst_n), .hcReset(hcReset),
    .run(run), .frameClk(frameClk), .ioAddr(ioAddr), .ioBe(ioBe), .ioWr(ioWr), .ioRd(ioRd),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
    .frame_index_counter(frame_index_counter), .entryAddr(entryAddr), .sofStart(sofStart));

  // Frame lengths in bench cycles; each frame clock tick is two of them.
  always @(posedge mclk)
  begin
    cyc = run ? cyc + 1 : 0;
    if (sofStart === 1'b1)
    begin
      lens.push_back(cyc);
      cyc = 0;
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic io_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge mclk);
    ioAddr = a;
    ioBe = be;
    ioWrData = d;
    ioWr = 1'b1;
    @(negedge mclk);
    ioWr = 1'b0;
  endtask

  // The answer is registered, so it stands in the cycle after the strobe.
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(negedge mclk);
    ioAddr = a;
    ioRd = 1'b1;
    @(negedge mclk);
    ioRd = 1'b0;
    check_val("read valid", 32'h1, {31'h0, ioRdValid});
    check_val("read data", exp, ioRdData);
  endtask

  // Bounded wait; a frame takes about 24000 bench cycles here.
  task automatic wait_sof(input int n);
    int k;
    k = 0;
    while (lens.size() < n && k < 30000)
    begin
      @(negedge mclk);
      k++;
    end
    check_val("frame seen", 32'h1, {31'h0, lens.size() >= n});
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    #(95000 * 40);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    rows = '{'{OFS_LIST_BASE, 4'hf, 32'hdead_b000, 32'hdead_b000},
             '{OFS_LIST_BASE, 4'h2, 32'h0000_5000, 32'hdead_5000},
             '{OFS_LIST_BASE, 4'h4, 32'h00a5_0000, 32'hdea5_5000},
             '{OFS_TIMING_ADJ, 4'h1, 32'h0000_00ff, 32'h0000_007f},
             '{OFS_TIMING_ADJ, 4'h1, 32'h0000_0005, 32'h0000_0005},
             '{OFS_TIMING_ADJ, 4'he, 32'hffff_ff00, 32'h0000_0005},
             '{8'h10, 4'hf, 32'hffff_ffff, 32'h0000_0000}};
    rst_n = 1'b0;
    hcReset = 1'b0;
    run = 1'b0;
    ioAddr = 8'h00;
    ioBe = 4'h0;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWrData = 32'h0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    reg_check(OFS_TIMING_ADJ, {25'h0, ADJ_RESET});
    // Byte-lane writes to base and adjust, and an unmapped offset reading zero.
    foreach (rows[i])
    begin
      io_write(rows[i].a, rows[i].be, rows[i].d);
      reg_check(rows[i].a, rows[i].exp);
    end
    // Base before run, shortest frame first, then a longer one queued mid-frame.
    io_write(OFS_LIST_BASE, 4'hf, 32'h1234_5000);
    io_write(OFS_TIMING_ADJ, 4'h1, 32'h0000_0000);
    @(negedge mclk);
    run = 1'b1;
    io_write(OFS_TIMING_ADJ, 4'h1, 32'h0000_007f);
    wait_sof(1);
    check_val("first length", 32'h1, {31'h0, lens[0] >= 23872 && lens[0] <= 23888});
    check_val("frame index", 32'h1, {21'h0, frame_index_counter});
    @(negedge mclk);
    check_val("entry", 32'h1234_5004, entryAddr);
    io_write(OFS_TIMING_ADJ, 4'h1, 32'h0000_0040);
    wait_sof(2);
    check_val("second length", 32'(2 * (int'(FRAME_LEN_BASE) + 127)), 32'(lens[1]));
    wait_sof(3);
    check_val("third length", 32'(2 * int'(FRAME_LEN_RESET)), 32'(lens[2]));
    check_val("frame index", 32'h3, {21'h0, frame_index_counter});
    @(negedge mclk);
    check_val("entry", 32'h1234_500c, entryAddr);
    // Controller reset restores the adjust value but keeps the base.
    io_write(OFS_TIMING_ADJ, 4'h1, 32'h0000_0011);
    @(negedge mclk);
    hcReset = 1'b1;
    @(negedge mclk);
    hcReset = 1'b0;
    check_val("index after reset", 32'h0, {21'h0, frame_index_counter});
    reg_check(OFS_TIMING_ADJ, {25'h0, ADJ_RESET});
    reg_check(OFS_LIST_BASE, 32'h1234_5000);
    // Software puts back its own copy of the adjust value after the reset.
    io_write(OFS_TIMING_ADJ, 4'h1, 32'h0000_0011);
    reg_check(OFS_TIMING_ADJ, 32'h0000_0011);
    // Global reset in mid-run.
    io_write(OFS_TIMING_ADJ, 4'h1, 32'h0000_0022);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    reg_check(OFS_TIMING_ADJ, {25'h0, ADJ_RESET});
    reg_check(OFS_LIST_BASE, LIST_BASE_RESET);
    complete_run();
  end
endmodule

`default_nettype wire
